//--- src/tpcc_pkg.sv
// shared constants and types for the prescaled capture/compare timer
package tpcc_pkg;
    // number of capture/compare channels
    localparam int NUM_CH = 2;
    // register offsets on the plain register port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI = 8'h01;
    localparam logic [7:0] ADDR_CNT_LO = 8'h02;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h03;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADDR_CH_BASE = 8'h05;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h03;
    // offsets inside one channel group
    localparam logic [7:0] CH_OFS_CFG = 8'h00;
    localparam logic [7:0] CH_OFS_HI = 8'h01;
    localparam logic [7:0] CH_OFS_LO = 8'h02;
    // control register fields
    localparam int CTRL_RST_BIT = 5;
    localparam int PS_LSB = 0;
    localparam logic [2:0] PS_RESET = 3'h0;
    localparam logic [2:0] PS_NONE = 3'h7;
    // interrupt status layout: overflow then one flag per channel
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_CH_LSB = 1;
    localparam int IRQ_W = NUM_CH + 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = '0;
    // counter limits and reset values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [5:0] DIV_RESET = 6'h00;
    // channel configuration, bit 5 down to bit 1 of the channel cfg register
    typedef struct packed {
        logic channel_mode_b;
        logic channel_mode_a;
        logic edge_level_b;
        logic edge_level_a;
        logic overflow_toggle_enable;
    } tpcc_cfg_t;
    localparam tpcc_cfg_t CFG_RESET = '0;
    localparam int CFG_LSB = 1;
    // decoded channel modes
    typedef enum logic [1:0] {
        TPCC_PRESET,
        TPCC_CAPTURE,
        TPCC_COMPARE,
        TPCC_BUFFERED
    } tpcc_mode_t;
endpackage

//--- src/tpcc_timer.sv
// prescaled 16-bit timer with capture/compare channels and a register port
// Functional notes
// - three-bit prescale select, codes 0-6, 7 stops
// - reset clears prescale select to divide-by-one
// - high byte read latches low byte
// - latched low byte held until low read
// - reset clears both counter bytes
// - counter reset bit clears the counter
// - both edge bits clear gives output preset
// - mode bits zero select input capture edges
// - mode a alone gives unbuffered compare actions
// - mode b gives buffered compare actions
// - edge bits clear releases pin to port
// - reset clears every channel edge bits
// - overflow toggles compare pin when enabled
// - reset clears every overflow toggle bit
// - overflow action beats simultaneous compare action
module tpcc_timer
    import tpcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rdata,
    input wire logic [NUM_CH-1:0] channel_pin_in,
    output logic [NUM_CH-1:0] channel_pin_out,
    output logic [NUM_CH-1:0] channel_pin_oe,
    output logic irq
);

    // mask of divider bits that must be zero for a tick at this select code
    function automatic logic [5:0] div_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // decode a channel configuration into its operating mode
    function automatic tpcc_mode_t ch_mode(input tpcc_cfg_t c);
        if (!c.edge_level_b && !c.edge_level_a) begin
            return TPCC_PRESET;
        end else if (c.channel_mode_b) begin
            return TPCC_BUFFERED;
        end else if (c.channel_mode_a) begin
            return TPCC_COMPARE;
        end else begin
            return TPCC_CAPTURE;
        end
    endfunction

    // register state
    logic [2:0] prescale_select; // divider select
    logic [5:0] div; // free prescaler chain
    logic [15:0] count; // main counter
    logic [7:0] hold_low; // low byte held by a high byte read
    logic low_latched; // hold_low is in use
    tpcc_cfg_t cfg [NUM_CH]; // channel configuration
    logic [15:0] value [NUM_CH]; // active compare or captured value
    logic [15:0] buffer [NUM_CH]; // shadow value for buffered mode
    logic [NUM_CH-1:0] pin_level; // driven pin level
    logic [IRQ_W-1:0] irq_status; // sticky event flags
    logic [IRQ_W-1:0] irq_mask; // interrupt enables
    logic [NUM_CH-1:0] sync1; // first synchroniser stage
    logic [NUM_CH-1:0] sync2; // second synchroniser stage
    logic [NUM_CH-1:0] pin_prev; // previous synchronised level

    // next values
    logic [2:0] next_prescale_select;
    logic [5:0] next_div;
    logic [15:0] next_count;
    logic [7:0] next_hold_low;
    logic next_low_latched;
    tpcc_cfg_t next_cfg [NUM_CH];
    logic [15:0] next_value [NUM_CH];
    logic [15:0] next_buffer [NUM_CH];
    logic [NUM_CH-1:0] next_pin_level;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [7:0] next_rdata;

    // decoded events
    logic tick; // prescaler output pulse
    logic ovf_evt; // counter wraps this cycle
    logic cnt_clear; // software counter reset
    logic [NUM_CH-1:0] cap_evt; // capture edge seen
    logic [NUM_CH-1:0] cmp_evt; // compare match seen
    logic [NUM_CH-1:0] ovf_tog; // overflow toggle applies

    // tick generation and counter events
    always_comb begin
        tick = ((div & div_mask(prescale_select)) == 6'h00) && (prescale_select != PS_NONE);
        ovf_evt = tick && (count == CNT_MAX);
        cnt_clear = wr_strobe && (addr == ADDR_CTRL) && wdata[CTRL_RST_BIT];
    end

    // per-channel event detection
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            // edge select: a = rising, b = falling, both = either
            cap_evt[c] = (ch_mode(cfg[c]) == TPCC_CAPTURE) &&
                ((cfg[c].edge_level_a && sync2[c] && !pin_prev[c]) ||
                 (cfg[c].edge_level_b && !sync2[c] && pin_prev[c]));
            cmp_evt[c] = (ch_mode(cfg[c]) inside {TPCC_COMPARE, TPCC_BUFFERED}) ||
                (cfg[c].channel_mode_a && ch_mode(cfg[c]) == TPCC_PRESET);
            cmp_evt[c] = cmp_evt[c] && tick && (count == value[c]);
            // toggle on overflow only for output compare channels
            ovf_tog[c] = ovf_evt && cfg[c].overflow_toggle_enable &&
                (ch_mode(cfg[c]) inside {TPCC_COMPARE, TPCC_BUFFERED});
        end
    end

    // counter, prescaler and byte latch next state
    always_comb begin
        next_prescale_select = prescale_select;
        next_div = div + 6'h01;
        next_count = count;
        next_hold_low = hold_low;
        next_low_latched = low_latched;
        if (tick) begin
            next_count = count + 16'h0001;
        end
        if (wr_strobe && addr == ADDR_CTRL) begin
            next_prescale_select = wdata[PS_LSB +: 3];
        end
        if (cnt_clear) begin
            next_count = CNT_RESET;
            next_div = DIV_RESET;
        end
        // high read grabs low byte unless already held
        if (rd_strobe && addr == ADDR_CNT_HI && !low_latched) begin
            next_hold_low = count[7:0];
            next_low_latched = 1'b1;
        end
        // only a low read releases the held byte
        if (rd_strobe && addr == ADDR_CNT_LO) begin
            next_low_latched = 1'b0;
        end
    end

    // channel registers, pin levels and flags next state
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_pin_level = pin_level;
        for (int c = 0; c < NUM_CH; c++) begin
            next_cfg[c] = cfg[c];
            next_value[c] = value[c];
            next_buffer[c] = buffer[c];
            // software writes to the channel group
            if (wr_strobe && addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_CFG) begin
                next_cfg[c] = wdata[CFG_LSB +: 5];
            end
            if (wr_strobe && addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_HI) begin
                if (ch_mode(cfg[c]) == TPCC_BUFFERED) begin
                    next_buffer[c][15:8] = wdata;
                end else begin
                    next_value[c][15:8] = wdata;
                end
            end
            if (wr_strobe && addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_LO) begin
                if (ch_mode(cfg[c]) == TPCC_BUFFERED) begin
                    next_buffer[c][7:0] = wdata;
                end else begin
                    next_value[c][7:0] = wdata;
                end
            end
            // buffered value becomes active at each overflow
            if (ovf_evt && ch_mode(cfg[c]) == TPCC_BUFFERED) begin
                next_value[c] = buffer[c];
            end
            // capture stores the counter
            if (cap_evt[c]) begin
                next_value[c] = count;
            end
            // pin action: overflow first, then compare action
            case (ch_mode(cfg[c]))
                TPCC_PRESET: begin
                    next_pin_level[c] = !cfg[c].channel_mode_a;
                end
                TPCC_COMPARE, TPCC_BUFFERED: begin
                    if (ovf_tog[c]) begin
                        next_pin_level[c] = !pin_level[c];
                    end else if (cmp_evt[c]) begin
                        // 01 toggle, 10 clear, 11 set
                        if (cfg[c].edge_level_b) begin
                            next_pin_level[c] = cfg[c].edge_level_a;
                        end else begin
                            next_pin_level[c] = !pin_level[c];
                        end
                    end
                end
                default: begin
                    next_pin_level[c] = pin_level[c];
                end
            endcase
        end
        // write one to clear, then set wins over clear
        if (wr_strobe && addr == ADDR_IRQ_STATUS) begin
            next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
        end
        if (wr_strobe && addr == ADDR_IRQ_MASK) begin
            next_irq_mask = wdata[IRQ_W-1:0];
        end
        next_irq_status[IRQ_OVF_BIT] = next_irq_status[IRQ_OVF_BIT] | ovf_evt;
        for (int c = 0; c < NUM_CH; c++) begin
            next_irq_status[IRQ_CH_LSB + c] = next_irq_status[IRQ_CH_LSB + c] |
                cap_evt[c] | cmp_evt[c];
        end
    end

    // read data mux, registered so it appears the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (rd_strobe) begin
            case (addr)
                ADDR_CTRL: next_rdata = {5'h00, prescale_select};
                ADDR_CNT_HI: next_rdata = count[15:8];
                ADDR_CNT_LO: next_rdata = low_latched ? hold_low : count[7:0];
                ADDR_IRQ_STATUS: next_rdata = 8'(irq_status);
                ADDR_IRQ_MASK: next_rdata = 8'(irq_mask);
                default: begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        if (addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_CFG) begin
                            next_rdata = {2'b00, cfg[c], 1'b0};
                        end
                        if (addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_HI) begin
                            next_rdata = value[c][15:8];
                        end
                        if (addr == ADDR_CH_BASE + 8'(c) * ADDR_CH_STRIDE + CH_OFS_LO) begin
                            next_rdata = value[c][7:0];
                        end
                    end
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prescale_select <= PS_RESET;
            div <= DIV_RESET;
            count <= CNT_RESET;
            hold_low <= 8'h00;
            low_latched <= 1'b0;
            pin_level <= '1;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            sync1 <= '0;
            sync2 <= '0;
            pin_prev <= '0;
            rdata <= 8'h00;
            for (int c = 0; c < NUM_CH; c++) begin
                cfg[c] <= CFG_RESET;
                value[c] <= CNT_RESET;
                buffer[c] <= CNT_RESET;
            end
        end else begin
            prescale_select <= next_prescale_select;
            div <= next_div;
            count <= next_count;
            hold_low <= next_hold_low;
            low_latched <= next_low_latched;
            pin_level <= next_pin_level;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            sync1 <= channel_pin_in;
            sync2 <= sync1;
            pin_prev <= sync2;
            rdata <= next_rdata;
            for (int c = 0; c < NUM_CH; c++) begin
                cfg[c] <= next_cfg[c];
                value[c] <= next_value[c];
                buffer[c] <= next_buffer[c];
            end
        end
    end

    // pin drive and interrupt output
    always_comb begin
        channel_pin_out = pin_level;
        irq = |(irq_status & irq_mask);
        for (int c = 0; c < NUM_CH; c++) begin
            // released to port when edge bits clear; input capture never drives
            channel_pin_oe[c] = ch_mode(cfg[c]) inside {TPCC_COMPARE, TPCC_BUFFERED};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_high_read;
        rd_strobe && addr == ADDR_CNT_HI && !low_latched;
    endsequence
    sequence s_no_low_read;
        !(rd_strobe && addr == ADDR_CNT_LO);
    endsequence

    chk_tick_stopped: assert property (prescale_select == PS_NONE |-> !tick)
        else $error("tick seen with prescaler code seven");
    chk_reset_values: assert property (disable iff (1'b0) !reset_n |=>
        prescale_select == PS_RESET && count == CNT_RESET && cfg[0] == CFG_RESET)
        else $error("reset did not clear select, counter or channel cfg");
    chk_latch_capture: assert property (s_high_read |=>
        low_latched && hold_low == $past(count[7:0]))
        else $error("high byte read did not latch low byte");
    chk_latch_hold: assert property (s_high_read ##1 s_no_low_read [*3] |->
        $stable(hold_low) && low_latched)
        else $error("held low byte changed without low read");
    chk_counter_clear: assert property (cnt_clear |=> count == CNT_RESET)
        else $error("counter reset bit did not clear counter");
    chk_counter_wrap: assert property (ovf_evt |=> count == CNT_RESET
        && irq_status[IRQ_OVF_BIT])
        else $error("overflow did not wrap counter or set flag");
    chk_count_step: assert property (tick && !cnt_clear && count != CNT_MAX |=>
        count == $past(count) + 16'h0001)
        else $error("counter did not advance on tick");
    chk_ovf_priority: assert property (ovf_tog[0] |=> pin_level[0] != $past(pin_level[0]))
        else $error("overflow toggle lost to compare action");
    chk_capture_flag: assert property (cap_evt[1] |=>
        irq_status[IRQ_CH_LSB + 1] && value[1] == $past(count))
        else $error("capture edge did not store counter and flag");
    chk_gpio_release: assert property (!cfg[1].edge_level_a && !cfg[1].edge_level_b |->
        !channel_pin_oe[1])
        else $error("channel drives pin with edge bits clear");
    chk_preset_level: assert property (ch_mode(cfg[0]) == TPCC_PRESET |=>
        pin_level[0] == !$past(cfg[0].channel_mode_a))
        else $error("preset level does not follow mode a");

endmodule

//--- bench/tpcc_pin_model.sv
// far-side model of the channel pins: an outside source plus the wire resolution
module tpcc_pin_model
    import tpcc_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic [NUM_CH-1:0] ext_level,
    input wire logic [NUM_CH-1:0] channel_pin_out,
    input wire logic [NUM_CH-1:0] channel_pin_oe,
    output logic [NUM_CH-1:0] channel_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NUM_CH-1:0] late_level; // outside level one clock late, a sluggish source

    // delay line for the slow source
    always_ff @(posedge clk) begin
        late_level <= ext_level;
    end

    // a driving channel owns its wire, otherwise the outside source sets it
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            channel_pin_in[i] = channel_pin_oe[i] ? channel_pin_out[i]
                                : (slow ? late_level[i] : ext_level[i]);
        end
    end
endmodule

//--- bench/testbench.sv
// self-checking bench for the prescaled capture/compare timer
module testbench
    import tpcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [2:0] ps; logic [15:0] count;} tpcc_ps_row_t;
    typedef struct packed {logic b; logic [1:0] els; logic init; logic level;} tpcc_cmp_row_t;
    typedef struct packed {logic [1:0] els; logic rise; logic flag;} tpcc_cap_row_t;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [7:0] rdata;
    logic [NUM_CH-1:0] pin_in;
    logic [NUM_CH-1:0] pin_out;
    logic [NUM_CH-1:0] pin_oe;
    logic irq;
    logic [NUM_CH-1:0] ext_level = 2'h0; // outside level of undriven pins
    logic slow = 1'b0; // outside source answers one clock late
    int num_errors = 0;
    int tests_run = 0;

    // counts after 256 cycles at each prescale code; code 7 holds the counter
    tpcc_ps_row_t ps_rows [8] = '{'{3'h0, 16'h0100}, '{3'h1, 16'h0080}, '{3'h2, 16'h0040},
        '{3'h3, 16'h0020}, '{3'h4, 16'h0010}, '{3'h5, 16'h0008}, '{3'h6, 16'h0004},
        '{3'h7, 16'h0000}};
    // compare rows: buffered, action code, preset level, level after one match
    tpcc_cmp_row_t cmp_rows [7] = '{'{1'h0, 2'h0, 1'h0, 1'h0}, '{1'h0, 2'h1, 1'h1, 1'h0},
        '{1'h0, 2'h2, 1'h1, 1'h0}, '{1'h0, 2'h3, 1'h0, 1'h1}, '{1'h1, 2'h1, 1'h0, 1'h1},
        '{1'h1, 2'h2, 1'h1, 1'h0}, '{1'h1, 2'h3, 1'h0, 1'h1}};
    // capture rows: edge code, edge direction, flag expected
    tpcc_cap_row_t cap_rows [6] = '{'{2'h1, 1'h1, 1'h1}, '{2'h1, 1'h0, 1'h0},
        '{2'h2, 1'h0, 1'h1}, '{2'h2, 1'h1, 1'h0}, '{2'h3, 1'h1, 1'h1}, '{2'h3, 1'h0, 1'h1}};

    tpcc_timer tpcc_timer_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));

    tpcc_pin_model tpcc_pin_model_i (.clk(clk), .slow(slow), .ext_level(ext_level),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .channel_pin_in(pin_in));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] expected, input string what);
        tests_run++;
        if (seen !== expected) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expected);
        end
    endtask

    // one-cycle write strobe
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask

    // let n edges land, then look at settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // count for exactly n cycles at one prescale code, then freeze the counter
    task automatic run_counter(input logic [2:0] ps, input int n);
        bus_write(ADDR_CTRL, {5'h00, ps});
        repeat (n - 2) @(posedge clk);
        bus_write(ADDR_CTRL, {5'h00, PS_NONE});
    endtask

    // channel cfg byte from its fields
    function automatic logic [7:0] cfg_byte(input logic b, input logic a, input logic [1:0] els,
                                            input logic tov);
        return {2'h0, b, a, els, tov, 1'b0};
    endfunction

    // single place where the run ends
    task automatic print_verdict();
        $display("checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end

    // main sequence
    initial begin
        tpcc_cmp_row_t r;
        tpcc_cap_row_t c;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // prescale table; 8'h27 stops and clears the counter
        foreach (ps_rows[i]) begin
            bus_write(ADDR_CTRL, 8'h27);
            run_counter(ps_rows[i].ps, 256);
            read_check(ADDR_CNT_HI, ps_rows[i].count[15:8], "count high");
            read_check(ADDR_CNT_LO, ps_rows[i].count[7:0], "count low");
        end
        // compare action table on channel 0
        foreach (cmp_rows[i]) begin
            r = cmp_rows[i];
            bus_write(ADDR_CTRL, 8'h27);
            bus_write(ADDR_CH_BASE + CH_OFS_LO, 8'h10);
            bus_write(ADDR_CH_BASE, cfg_byte(r.b, !r.init, 2'h0, 1'b0));
            settle(2);
            check(8'(pin_out[0]), 8'(r.init), "preset level");
            check(8'(pin_oe[0]), 8'h00, "preset released");
            bus_write(ADDR_CH_BASE, cfg_byte(r.b, !r.b, r.els, 1'b0));
            settle(1);
            check(8'(pin_oe[0]), 8'(r.els != 2'h0), "compare drive");
            run_counter(3'h0, 32);
            settle(2);
            check(8'(pin_out[0]), 8'(r.level), "match action");
            read_check(ADDR_IRQ_STATUS, 8'h02, "match flag");
            bus_write(ADDR_IRQ_STATUS, 8'h07);
        end
        // capture edge table on channel 1, source alternating prompt and slow
        foreach (cap_rows[i]) begin
            c = cap_rows[i];
            @(posedge clk);
            ext_level[1] <= !c.rise;
            slow <= i[0];
            bus_write(ADDR_CH_BASE + ADDR_CH_STRIDE, cfg_byte(1'b0, 1'b0, c.els, 1'b1));
            repeat (8) @(posedge clk);
            bus_write(ADDR_IRQ_STATUS, 8'h07);
            @(posedge clk);
            ext_level[1] <= c.rise;
            settle(8);
            check(8'(pin_oe[1]), 8'h00, "capture released");
            read_check(ADDR_IRQ_STATUS, {5'h00, c.flag, 2'h0}, "capture flag");
        end
        // low byte latch across two high reads
        bus_write(ADDR_CTRL, 8'h27);
        read_check(ADDR_CTRL, 8'h07, "reset bit reads 0");
        run_counter(3'h0, 300);
        read_check(ADDR_CNT_HI, 8'h01, "first high");
        run_counter(3'h0, 260);
        read_check(ADDR_CNT_HI, 8'h02, "second high");
        read_check(ADDR_CNT_LO, 8'h2C, "held low");
        read_check(ADDR_CNT_HI, 8'h02, "fresh high");
        read_check(ADDR_CNT_LO, 8'h30, "fresh low");
        bus_write(ADDR_CNT_HI, 8'h5A);
        bus_write(8'hF0, 8'hFF);
        read_check(8'hF0, 8'h00, "unmapped read");
        bus_write(ADDR_CTRL, 8'h27);
        read_check(ADDR_CNT_HI, 8'h00, "cleared high");
        read_check(ADDR_CNT_LO, 8'h00, "cleared low");
        // overflow meets a clear-on-match at FFFF with toggle on overflow
        bus_write(ADDR_CH_BASE, cfg_byte(1'b0, 1'b1, 2'h0, 1'b0));
        bus_write(ADDR_CH_BASE + CH_OFS_HI, 8'hFF);
        bus_write(ADDR_CH_BASE + CH_OFS_LO, 8'hFF);
        bus_write(ADDR_CH_BASE, cfg_byte(1'b0, 1'b1, 2'h2, 1'b1));
        bus_write(ADDR_IRQ_STATUS, 8'h07);
        run_counter(3'h0, 65540);
        settle(2);
        check(8'(pin_out[0]), 8'h01, "overflow wins");
        check(8'(irq), 8'h00, "masked overflow");
        read_check(ADDR_CNT_HI, 8'h00, "wrapped high");
        read_check(ADDR_CNT_LO, 8'h04, "wrapped low");
        bus_write(ADDR_IRQ_MASK, 8'h01);
        settle(1);
        check(8'(irq), 8'h01, "overflow interrupt");
        bus_write(ADDR_IRQ_STATUS, 8'h01);
        settle(1);
        check(8'(irq), 8'h00, "interrupt cleared");
        // second reset in mid-run
        bus_write(ADDR_CTRL, 8'h03);
        @(posedge clk);
        reset_n <= 1'b0;
        settle(3);
        check({3'h0, pin_out, pin_oe, irq}, 8'h18, "pins in reset");
        check(rdata, 8'h00, "read data in reset");
        @(posedge clk);
        reset_n <= 1'b1;
        read_check(ADDR_CTRL, 8'h00, "prescale after reset");
        read_check(ADDR_CH_BASE, 8'h00, "cfg after reset");
        read_check(ADDR_IRQ_MASK, 8'h00, "mask after reset");
        read_check(ADDR_CNT_HI, 8'h00, "count after reset");
        print_verdict();
    end
endmodule
